// ### jflm_mapper.sv
// Purpose: Frame assembly and lane mapping for a two-channel serial link
// Assumes: One clock, APB register access, inputs synchronous to pclk
// Notes: Each lane emits one octet per clock, upper byte of a sample first
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "jflm_defs.svh"

module jflm_mapper #(
   parameter int MAX_LANE_MBPS = `JFLM_MAX_LANE_MBPS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire jflm_pkg::jflm_chan_type chan_a_samples,
   input wire jflm_pkg::jflm_chan_type chan_b_samples,
   output logic [7:0] chan_a_lane_zero,
   output logic [7:0] chan_a_lane_one,
   output logic [7:0] chan_a_lane_two,
   output logic [7:0] chan_a_lane_three,
   output logic [7:0] chan_b_lane_zero,
   output logic [7:0] chan_b_lane_one,
   output logic [7:0] chan_b_lane_two,
   output logic [7:0] chan_b_lane_three,
   output logic [7:0] lane_active,
   output logic octet_valid,
   output logic frame_start,
   output logic [1:0] link_format_sel_first,
   output logic link_format_sel_second,
   output logic link_format_sel_third,
   output logic pll_mult_40x
);

   // ****************************************
   // Decoders
   // ****************************************
   function automatic jflm_pkg::jflm_info_type fmt_info(input jflm_pkg::jflm_fmt_type fmt);
      jflm_pkg::jflm_info_type r;
      r = '0;
      r.fmt_ok = 1'b1;
      unique case (fmt)
         jflm_pkg::JFLM_FMT_4211: begin
            r.sel_first = 2'h1;
            r.sel_second = 1'b1;
            r.lane_mask = 4'h3;
            r.octets = 3'h1;
         end
         jflm_pkg::JFLM_FMT_4222: begin
            r.sel_first = 2'h1;
            r.lane_mask = 4'h3;
            r.octets = 3'h2;
         end
         jflm_pkg::JFLM_FMT_2221: begin
            r.pll40 = 1'b1;
            r.sel_third = 1'b1;
            r.lane_mask = 4'h2;
            r.octets = 3'h2;
         end
         jflm_pkg::JFLM_FMT_8821: begin
            r.sel_first = 2'h1;
            r.lane_mask = 4'hF;
            r.octets = 3'h2;
         end
         jflm_pkg::JFLM_FMT_4841: begin
            r.pll40 = 1'b1;
            r.sel_first = 2'h2;
            r.lane_mask = 4'h6;
            r.octets = 3'h4;
         end
         default: r.fmt_ok = 1'b0;
      endcase
      return r;
   endfunction : fmt_info

   function automatic logic dec_ok(input jflm_pkg::jflm_fmt_type fmt, input logic [7:0] dec);
      logic base;
      logic wide;
      base = (dec == 8'h08) || (dec == 8'h09) || (dec == 8'h0A) || (dec == 8'h0C) ||
             (dec == 8'h10) || (dec == 8'h12) || (dec == 8'h14);
      wide = (dec == 8'h18) || (dec == 8'h20);
      // Only the 40x-PLL formats (2221, 4841) accept the top decimations 0x18 and 0x20
      if ((fmt == jflm_pkg::JFLM_FMT_2221) || (fmt == jflm_pkg::JFLM_FMT_4841)) begin
         return base || wide;
      end
      return base;
   endfunction : dec_ok

   function automatic logic [3:0][31:0] map_chan(input jflm_pkg::jflm_fmt_type fmt,
                                                 input jflm_pkg::jflm_chan_type s);
      logic [3:0][31:0] w;
      w = '0;
      unique case (fmt)
         jflm_pkg::JFLM_FMT_4211: begin
            w[0] = {s.b1i[15:8], 24'h000000};
            w[1] = {s.b1i[7:0], 24'h000000};
         end
         jflm_pkg::JFLM_FMT_4222: begin
            w[0] = {s.b1i, 16'h0000};
            w[1] = {s.b1q, 16'h0000};
         end
         jflm_pkg::JFLM_FMT_2221: w[1] = {s.b1i, 16'h0000};
         jflm_pkg::JFLM_FMT_8821: begin
            w[0] = {s.b1i, 16'h0000};
            w[1] = {s.b1q, 16'h0000};
            w[2] = {s.b2i, 16'h0000};
            w[3] = {s.b2q, 16'h0000};
         end
         jflm_pkg::JFLM_FMT_4841: begin
            w[1] = {s.b1i, s.b1q};
            w[2] = {s.b2i, s.b2q};
         end
         default: w = '0;
      endcase
      return w;
   endfunction : map_chan

   // ****************************************
   // Registers
   // ****************************************
   logic en_ff;
   jflm_pkg::jflm_fmt_type fmt_ff;
   logic [7:0] dec_ff;
   logic [15:0] sclk_ff;
   logic [31:0] fcnt_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic cfg_ok_ff;
   jflm_pkg::jflm_info_type info_ff;
   jflm_pkg::jflm_state_type state_ff;
   jflm_pkg::jflm_state_type nxt_state;
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic ready_ff;
   logic valid_ff;
   logic start_ff;
   logic [1:0][3:0][31:0] shreg_ff;
   jflm_pkg::jflm_info_type cur_info;
   logic nxt_cfg_ok;
   logic mapped;
   logic take;
   logic last;
   logic [31:0] rate_lhs;
   logic [31:0] rate_rhs;
   logic [31:0] stat_word;

   assign cur_info = fmt_info(fmt_ff);
   assign rate_lhs = 32'(sclk_ff) * (cur_info.pll40 ? `JFLM_PLL_HIGH : `JFLM_PLL_LOW);
   assign rate_rhs = 32'(MAX_LANE_MBPS) * 32'(dec_ff);
   // Cross-multiplied so no divider is needed
   assign nxt_cfg_ok = en_ff && cur_info.fmt_ok && dec_ok(fmt_ff, dec_ff) &&
                       (rate_lhs <= rate_rhs);
   assign mapped = (paddr == `JFLM_OFS_CTRL) || (paddr == `JFLM_OFS_SCLK) ||
                   (paddr == `JFLM_OFS_STAT) || (paddr == `JFLM_OFS_FCNT);

   always_comb begin
      stat_word = '0;
      stat_word[`JFLM_STAT_OK] = cfg_ok_ff;
      stat_word[`JFLM_STAT_RUN] = (state_ff == jflm_pkg::JFLM_ST_SEND);
      stat_word[`JFLM_STAT_SEL1_HI:`JFLM_STAT_SEL1_LO] = info_ff.sel_first;
      stat_word[`JFLM_STAT_SEL2] = info_ff.sel_second;
      stat_word[`JFLM_STAT_SEL3] = info_ff.sel_third;
      stat_word[`JFLM_STAT_PLL40] = info_ff.pll40;
      stat_word[`JFLM_STAT_MASK_HI:`JFLM_STAT_MASK_LO] = info_ff.lane_mask;
      stat_word[`JFLM_STAT_OCT_HI:`JFLM_STAT_OCT_LO] = info_ff.octets;
   end

   // ****************************************
   // APB slave
   // ****************************************
   // One wait-free access phase: answer is ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         pready_ff <= psel && !penable;
         pslverr_ff <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `JFLM_OFS_CTRL: prdata_ff <= {16'h0000, dec_ff, 4'h0, fmt_ff, en_ff};
               `JFLM_OFS_SCLK: prdata_ff <= {16'h0000, sclk_ff};
               `JFLM_OFS_STAT: prdata_ff <= stat_word;
               `JFLM_OFS_FCNT: prdata_ff <= fcnt_ff;
               default: prdata_ff <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_ff <= 1'b0;
         fmt_ff <= jflm_pkg::jflm_fmt_type'(`JFLM_RST_FMT);
         dec_ff <= `JFLM_RST_DEC;
         sclk_ff <= `JFLM_RST_SCLK;
      end else if (psel && penable && pready_ff && pwrite) begin
         if (paddr == `JFLM_OFS_CTRL) begin
            en_ff <= pwdata[`JFLM_CTRL_EN];
            fmt_ff <= jflm_pkg::jflm_fmt_type'(pwdata[`JFLM_CTRL_FMT_HI:`JFLM_CTRL_FMT_LO]);
            dec_ff <= pwdata[`JFLM_CTRL_DEC_HI:`JFLM_CTRL_DEC_LO];
         end
         if (paddr == `JFLM_OFS_SCLK) begin
            sclk_ff <= pwdata[15:0];
         end
      end
   end

   // ****************************************
   // Link configuration
   // ****************************************
   // Codes only change while the framer is idle; back-to-back frames after a CTRL write map lanes by the new fmt_ff under the old codes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ok_ff <= 1'b0;
         info_ff <= '0;
      end else begin
         cfg_ok_ff <= nxt_cfg_ok;
         if (state_ff == jflm_pkg::JFLM_ST_IDLE) begin
            info_ff <= nxt_cfg_ok ? cur_info : '0;
         end
      end
   end

   // ****************************************
   // Framer
   // ****************************************
   assign take = sample_valid && ready_ff;
   assign last = (cnt_ff == info_ff.octets - 3'h1);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      if (take) begin
         nxt_state = jflm_pkg::JFLM_ST_SEND;
         nxt_cnt = 3'h0;
      end else begin
         unique case (state_ff)
            jflm_pkg::JFLM_ST_IDLE: nxt_cnt = 3'h0;
            jflm_pkg::JFLM_ST_SEND: begin
               if (last) begin
                  nxt_state = jflm_pkg::JFLM_ST_IDLE;
                  nxt_cnt = 3'h0;
               end else begin
                  nxt_cnt = cnt_ff + 3'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= jflm_pkg::JFLM_ST_IDLE;
         cnt_ff <= 3'h0;
         ready_ff <= 1'b0;
         valid_ff <= 1'b0;
         start_ff <= 1'b0;
         fcnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         // Ready only when the next frame can follow the last octet directly
         // Any register write may change the layout, so hold off one cycle
         ready_ff <= cfg_ok_ff && nxt_cfg_ok && (info_ff.octets != 3'h0) &&
                     !(psel && penable && pready_ff && pwrite) &&
                     ((nxt_state == jflm_pkg::JFLM_ST_IDLE) ||
                      (nxt_cnt == info_ff.octets - 3'h1));
         valid_ff <= take || ((state_ff == jflm_pkg::JFLM_ST_SEND) && !last);
         start_ff <= take;
         if (take) begin
            fcnt_ff <= fcnt_ff + 32'h00000001;
         end
      end
   end

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            shreg_ff[ch] <= '0;
         end else if (take) begin
            shreg_ff[ch] <= map_chan(fmt_ff, (ch == 0) ? chan_a_samples : chan_b_samples);
         end else if ((state_ff == jflm_pkg::JFLM_ST_SEND) && !last) begin
            for (int ln = 0; ln < 4; ln++) begin
               shreg_ff[ch][ln] <= {shreg_ff[ch][ln][23:0], 8'h00};
            end
         end else if (state_ff == jflm_pkg::JFLM_ST_SEND) begin
            shreg_ff[ch] <= '0;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign sample_ready = ready_ff;
   assign chan_a_lane_zero = shreg_ff[0][0][31:24];
   assign chan_a_lane_one = shreg_ff[0][1][31:24];
   assign chan_a_lane_two = shreg_ff[0][2][31:24];
   assign chan_a_lane_three = shreg_ff[0][3][31:24];
   assign chan_b_lane_zero = shreg_ff[1][0][31:24];
   assign chan_b_lane_one = shreg_ff[1][1][31:24];
   assign chan_b_lane_two = shreg_ff[1][2][31:24];
   assign chan_b_lane_three = shreg_ff[1][3][31:24];
   assign lane_active = {info_ff.lane_mask, info_ff.lane_mask};
   assign octet_valid = valid_ff;
   assign frame_start = start_ff;
   assign link_format_sel_first = info_ff.sel_first;
   assign link_format_sel_second = info_ff.sel_second;
   assign link_format_sel_third = info_ff.sel_third;
   assign pll_mult_40x = info_ff.pll40;

endmodule : jflm_mapper

// ### jflm_defs.svh
// Purpose: Offsets, field positions and reset values of the frame/lane mapper
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Definitions only
`ifndef JFLM_DEFS_SVH
`define JFLM_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define JFLM_OFS_CTRL 8'h00
`define JFLM_OFS_SCLK 8'h04
`define JFLM_OFS_STAT 8'h08
`define JFLM_OFS_FCNT 8'h0C

// ****************************************
// Field positions
// ****************************************
`define JFLM_CTRL_EN 0
`define JFLM_CTRL_FMT_LO 1
`define JFLM_CTRL_FMT_HI 3
`define JFLM_CTRL_DEC_LO 8
`define JFLM_CTRL_DEC_HI 15
`define JFLM_STAT_OK 0
`define JFLM_STAT_RUN 1
`define JFLM_STAT_SEL1_LO 2
`define JFLM_STAT_SEL1_HI 3
`define JFLM_STAT_SEL2 4
`define JFLM_STAT_SEL3 5
`define JFLM_STAT_PLL40 6
`define JFLM_STAT_MASK_LO 8
`define JFLM_STAT_MASK_HI 11
`define JFLM_STAT_OCT_LO 12
`define JFLM_STAT_OCT_HI 14

// ****************************************
// Reset values and limits
// ****************************************
`define JFLM_RST_FMT 3'h0
`define JFLM_RST_DEC 8'h08
`define JFLM_RST_SCLK 16'h0BB8
`define JFLM_MAX_LANE_MBPS 32'h000030D4
`define JFLM_PLL_LOW 32'h00000014
`define JFLM_PLL_HIGH 32'h00000028

`endif

// ### jflm_pkg.sv
// Purpose: Types shared by the frame/lane mapper
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Constants live in jflm_defs.svh
package jflm_pkg;

   typedef enum logic [2:0] {
      JFLM_FMT_4211 = 3'h0,
      JFLM_FMT_4222 = 3'h1,
      JFLM_FMT_2221 = 3'h2,
      JFLM_FMT_8821 = 3'h3,
      JFLM_FMT_4841 = 3'h4
   } jflm_fmt_type;

   // One frame of samples for one channel; real modes use b1i only
   typedef struct packed {
      logic [15:0] b1i;
      logic [15:0] b1q;
      logic [15:0] b2i;
      logic [15:0] b2q;
   } jflm_chan_type;

   typedef struct packed {
      logic fmt_ok;
      logic pll40;
      logic [1:0] sel_first;
      logic sel_second;
      logic sel_third;
      logic [3:0] lane_mask;
      logic [2:0] octets;
   } jflm_info_type;

   typedef enum logic [1:0] {
      JFLM_ST_IDLE = 2'b00,
      JFLM_ST_SEND = 2'b01
   } jflm_state_type;

endpackage : jflm_pkg

// ### jflm_mapper_chk.sv
// Purpose: Port-level assertions for the frame/lane mapper
// Assumes: One pclk domain, presetn active low
// Notes: Bound from the testbench top file
`timescale 1ns/1ns
module jflm_mapper_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic [7:0] chan_a_lane_zero,
   input wire logic [7:0] chan_a_lane_three,
   input wire logic [7:0] lane_active,
   input wire logic octet_valid,
   input wire logic frame_start,
   input wire logic [1:0] link_format_sel_first,
   input wire logic link_format_sel_second,
   input wire logic link_format_sel_third,
   input wire logic pll_mult_40x
);
   logic [3:0] mask_a;
   assign mask_a = lane_active[3:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************************************
   // Sequences
   // ****************************************
   sequence s_setup;
      psel && !penable;
   endsequence
   // Four-octet frame must not be cut short by a new start
   sequence s_four_octets;
      octet_valid ##1 (octet_valid && !frame_start) [*3];
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   a_pready_pulse: assert property (s_setup |=> pready ##1 !pready)
      else $error("pready is not a one-cycle answer");
   a_unmapped_error: assert property (psel && !penable && paddr > 8'h0C |=> pready && pslverr)
      else $error("unmapped address not refused");
   a_frame_follows_take: assert property (sample_valid && sample_ready |=> frame_start && octet_valid)
      else $error("frame did not start after take");
   a_codes_four_lane: assert property (octet_valid && mask_a == 4'h6 |->
      link_format_sel_first == 2'h2 && !link_format_sel_second && !link_format_sel_third && pll_mult_40x)
      else $error("four-lane complex codes wrong");
   a_codes_eight_lane: assert property (octet_valid && mask_a == 4'hF |->
      link_format_sel_first == 2'h1 && !link_format_sel_second && !link_format_sel_third && !pll_mult_40x)
      else $error("eight-lane complex codes wrong");
   a_codes_two_lane: assert property (octet_valid && mask_a == 4'h2 |->
      link_format_sel_first == 2'h0 && !link_format_sel_second && link_format_sel_third && pll_mult_40x)
      else $error("two-lane real codes wrong");
   a_chan_mirror: assert property (lane_active[7:4] == mask_a)
      else $error("channel lane groups differ");
   a_unused_lanes_zero: assert property (octet_valid && mask_a == 4'h6 |->
      chan_a_lane_zero == 8'h00 && chan_a_lane_three == 8'h00)
      else $error("unused lane not zero");
   a_wide_frame_len: assert property (frame_start && mask_a == 4'h6 |-> s_four_octets)
      else $error("four-octet frame length wrong");
endmodule : jflm_mapper_chk

// ### jflm_rx_model.sv
// Purpose: Link receiver model that gathers lane octets per frame
// Assumes: One octet per lane per pclk while octet_valid
// Notes: Each lane word restarts at frame_start, last octet lowest
`timescale 1ns/1ns
module jflm_rx_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [63:0] lanes,
   input wire logic octet_valid,
   input wire logic frame_start,
   output logic [31:0] rx_word [8]
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_word <= '{default: 32'h0};
      end else if (octet_valid) begin
         for (int i = 0; i < 8; i++) begin
            rx_word[i] <= {(frame_start ? 24'h0 : rx_word[i][23:0]), lanes[8*i +: 8]};
         end
      end
   end
endmodule : jflm_rx_model

// ### jesd_frame_lane_mapper_test.sv
// Purpose: Self-checking bench for the frame/lane mapper
// Assumes: APB master tasks, receiver model on the lanes
// Notes: Decimation 10 keeps every format inside the lane rate limit
`timescale 1ns/1ns
`include "jflm_defs.svh"
module jesd_frame_lane_mapper_test;
   localparam logic [63:0] SA0 = 64'hA1A2_A3A4_A5A6_A7A8;
   localparam logic [63:0] SA1 = 64'hC1C2_C3C4_C5C6_C7C8;
   localparam logic [63:0] SB0 = 64'hB1B2_B3B4_B5B6_B7B8;
   localparam logic [63:0] SB1 = 64'hD1D2_D3D4_D5D6_D7D8;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, sample_ready, octet_valid, frame_start, sel_second, sel_third, pll40;
   logic sample_valid = 1'b0;
   jflm_pkg::jflm_chan_type chan_a = '0, chan_b = '0;
   logic [7:0] lane [8];
   logic [7:0] lane_active;
   logic [1:0] sel_first;
   logic [31:0] rx_word [8];
   int n_errors = 0, tests_run = 0;
   logic [2:0] oct_t [5] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h4};
   logic [3:0] mask_t [5] = '{4'h3, 4'h3, 4'h2, 4'hF, 4'h6};
   logic [4:0] code_t [5] = '{5'h05, 5'h01, 5'h18, 5'h01, 5'h12};
   always #2 pclk = ~pclk;
   jflm_mapper dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .chan_a_samples(chan_a), .chan_b_samples(chan_b),
      .chan_a_lane_zero(lane[0]), .chan_a_lane_one(lane[1]), .chan_a_lane_two(lane[2]),
      .chan_a_lane_three(lane[3]), .chan_b_lane_zero(lane[4]), .chan_b_lane_one(lane[5]),
      .chan_b_lane_two(lane[6]), .chan_b_lane_three(lane[7]), .lane_active(lane_active),
      .octet_valid(octet_valid), .frame_start(frame_start), .link_format_sel_first(sel_first),
      .link_format_sel_second(sel_second), .link_format_sel_third(sel_third), .pll_mult_40x(pll40));
   jflm_rx_model rx_u (.pclk(pclk), .presetn(presetn), .octet_valid(octet_valid), .frame_start(frame_start),
      .lanes({lane[7], lane[6], lane[5], lane[4], lane[3], lane[2], lane[1], lane[0]}), .rx_word(rx_word));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic stop_test;
      $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never reassigns psel in this time step
      @(posedge pclk);
   endtask : apb
   task automatic send(input logic [63:0] a, input logic [63:0] b);
      chan_a <= a;
      chan_b <= b;
      sample_valid <= 1'b1;
      do @(posedge pclk); while (sample_ready !== 1'b1);
   endtask : send
   // Lane word after one frame, as the receiver model gathers it
   function automatic logic [31:0] exp_word(input logic [2:0] f, input int ln, input jflm_pkg::jflm_chan_type s);
      case (f)
         3'h0: return ln == 0 ? {24'h0, s.b1i[15:8]} : (ln == 1 ? {24'h0, s.b1i[7:0]} : 32'h0);
         3'h1: return ln == 0 ? {16'h0, s.b1i} : (ln == 1 ? {16'h0, s.b1q} : 32'h0);
         3'h2: return ln == 1 ? {16'h0, s.b1i} : 32'h0;
         3'h3: return {16'h0, s[63 - 16*ln -: 16]};
         default: return ln == 1 ? {s.b1i, s.b1q} : (ln == 2 ? {s.b2i, s.b2q} : 32'h0);
      endcase
   endfunction : exp_word
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      logic [31:0] rd;
      logic err;
      logic [2:0] bad_fmt [4];
      logic [7:0] bad_dec [4];
      logic ok_t [4];
      bad_fmt = '{3'h3, 3'h4, 3'h4, 3'h3};
      bad_dec = '{8'h18, 8'h20, 8'h08, 8'h08};
      ok_t = '{1'b0, 1'b1, 1'b0, 1'b1};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `JFLM_OFS_CTRL, 32'h0, rd, err);
      check(rd, 32'h0000_0800);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      check({rd[30:0], err}, 32'h0000_0001);
      for (int f = 0; f < 5; f++) begin
         apb(1'b1, `JFLM_OFS_CTRL, {16'h0, 8'h0A, 4'h0, f[2:0], 1'b1}, rd, err);
         send(SA0, SB0);
         send(SA1, SB1);
         sample_valid <= 1'b0;
         repeat (6) @(posedge pclk);
         for (int i = 0; i < 8; i++) begin
            check(rx_word[i], exp_word(f[2:0], i % 4, (i < 4) ? SA1 : SB1));
         end
         apb(1'b0, `JFLM_OFS_STAT, 32'h0, rd, err);
         check({17'h0, rd[14:0]}, {17'h0, oct_t[f], mask_t[f], 1'b0, code_t[f], 2'b01});
      end
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `JFLM_OFS_CTRL, {16'h0, bad_dec[k], 4'h0, bad_fmt[k], 1'b1}, rd, err);
         repeat (2) @(posedge pclk);
         apb(1'b0, `JFLM_OFS_STAT, 32'h0, rd, err);
         check({31'h0, rd[0]}, {31'h0, ok_t[k]});
         check({31'h0, sample_ready}, {31'h0, ok_t[k]});
      end
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge pclk);
      n_errors++;
      stop_test();
   end
endmodule : jesd_frame_lane_mapper_test
bind jflm_mapper jflm_mapper_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .sample_ready(sample_ready),
   .chan_a_lane_zero(chan_a_lane_zero), .chan_a_lane_three(chan_a_lane_three), .lane_active(lane_active),
   .octet_valid(octet_valid), .frame_start(frame_start), .link_format_sel_first(link_format_sel_first),
   .link_format_sel_second(link_format_sel_second), .link_format_sel_third(link_format_sel_third),
   .pll_mult_40x(pll_mult_40x));
